// ---- rxcnc_map.vh ----
/*
 constants of the receiver configuration and noise control block: register
 layouts, reset values, frame positions and timing counts.
 assumes a 100 mhz mclk and an internal timing clock made by a divider.
*/
`ifndef RXCNC_MAP_VH
`define RXCNC_MAP_VH
// Summary of operation
// R1 - data clock after line match plus delay
// R2 - suppression on: stream end enters check
// R3 - final high period gives band pulse; the code gives the pulse only when demod_data is low at the stream end
// R4 - suppression off: noise passes, stay receiving
// R5 - host pulls polling low, then off
// R6 - off: start-up, check, skip sleep
// R7 - host raises polling pin to resume
// R8 - two 12-bit registers written over line
// R9 - supply dip shows marker; host reprograms
// R10 - reset loads both register defaults
// R11 - first bit one means off command
// R12 - second bit selects target register
// R13 - stop bit zero commits, one discards
// R14 - operation register field layout
// R15 - window register limits, msb first
// R16 - band code picks window scale
// R17 - check count code picks bit count
// R18 - sleep count times scale times 1024
// R19 - fifteen bits assembled first bit first
// R20 - dip reloads defaults, marker until write

// register reset values
`define RXCNC_OP_RESET 12'h119
`define RXCNC_WIN_RESET 12'h569
// operation register fields
`define RXCNC_OP_BAND 11:10
`define RXCNC_OP_CHK 9:8
`define RXCNC_OP_MOD 7
`define RXCNC_OP_SLEEP 6:2
`define RXCNC_OP_XSLEEP 1
`define RXCNC_OP_NOISE 0
// window register fields
`define RXCNC_WIN_MIN 11:6
`define RXCNC_WIN_MAX 5:0
// frame bit positions, first bit lands at the top
`define RXCNC_FR_OFF 14
`define RXCNC_FR_SEL 13
`define RXCNC_FR_PAY 12:1
`define RXCNC_FR_STOP 0
`define RXCNC_FR_LAST 4'he
// bit check counts
`define RXCNC_CHK_N0 4'h0
`define RXCNC_CHK_N1 4'h3
`define RXCNC_CHK_N2 4'h6
`define RXCNC_CHK_N3 4'h9
// sleep encoding
`define RXCNC_SLEEP_PERM 5'h1f
`define RXCNC_SLEEP_ZERO 5'h00
// timing
`define RXCNC_MCLK_MHZ 100
`define RXCNC_TCLK_NS 2000
`define RXCNC_TCLK_CYC ((`RXCNC_TCLK_NS * `RXCNC_MCLK_MHZ) / 1000)
`define RXCNC_TDELAY2_NS 500
`define RXCNC_TDELAY2_CYC ((`RXCNC_TDELAY2_NS * `RXCNC_MCLK_MHZ + 999) / 1000)
`define RXCNC_EOS_PULSE_TICKS 6'h04
`define RXCNC_PROG_ONE_TICKS 4'h4
`define RXCNC_PROG_GAP_TICKS 7'h40
`endif

// ---- rxcnc_buf2.v ----
/*
 two-entry buffer for received programming frames.
 assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/100ps
module rxcnc_buf2 (
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [14:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [14:0] out_data
);
    reg [14:0] slot0_ff;
    reg [14:0] slot1_ff;
    reg wr_ff;
    reg rd_ff;
    reg [1:0] cnt_ff;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_ff != 2'h2);
    assign out_valid = (cnt_ff != 2'h0);
    assign out_data = rd_ff ? slot1_ff : slot0_ff;

    // pointers and occupancy; a push into a full buffer is refused
    always @(posedge mclk) begin
        if (!reset_n) begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            cnt_ff <= 2'h0;
            slot0_ff <= 15'h0000;
            slot1_ff <= 15'h0000;
        end else begin
            if (push && !wr_ff)
                slot0_ff <= in_data;
            if (push && wr_ff)
                slot1_ff <= in_data;
            if (push)
                wr_ff <= ~wr_ff;
            if (pop)
                rd_ff <= ~rd_ff;
            if (push && !pop)
                cnt_ff <= cnt_ff + 2'h1;
            else if (pop && !push)
                cnt_ff <= cnt_ff - 2'h1;
        end
    end
endmodule // rxcnc_buf2

// ---- rxcnc_edge_win.v ----
/*
 edge distance timer: classifies the time since the last edge against the
 single and double period windows.
 assumes lim_max is not below lim_min and tick is a one-cycle enable.
*/
`timescale 1ns/100ps
module rxcnc_edge_win (
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // strobes
    input wire tick,
    input wire edge_seen,
    // window settings
    input wire [5:0] lim_min,
    input wire [5:0] lim_max,
    input wire [1:0] scale_log2,
    // classification of the running distance
    output wire in_t,
    output wire in_2t,
    output wire over
);
    reg [10:0] dist_ff;
    wire [6:0] sum = {1'b0, lim_min} + {1'b0, lim_max};
    wire [5:0] diff = lim_max - lim_min;
    wire [5:0] half_dn = {1'b0, diff[5:1]};
    wire [5:0] half_up = half_dn + {5'h00, diff[0]};
    // half-integers round up on both double-period limits
    wire [7:0] lo2 = {1'b0, sum} - {2'h0, half_dn};
    wire [7:0] hi2 = {1'b0, sum} + {2'h0, half_up};
    wire [10:0] lo_t = {5'h00, lim_min} << scale_log2; // [R16]
    wire [10:0] hi_t = {5'h00, lim_max} << scale_log2; // [R16]
    wire [10:0] lo_2t = {3'h0, lo2} << scale_log2;
    wire [10:0] hi_2t = {3'h0, hi2} << scale_log2;

    assign in_t = (dist_ff >= lo_t) && (dist_ff <= hi_t);
    assign in_2t = (dist_ff >= lo_2t) && (dist_ff <= hi_2t);
    assign over = (dist_ff > hi_2t);

    // distance restarts on every edge and saturates while idle
    always @(posedge mclk) begin
        if (!reset_n)
            dist_ff <= 11'h000;
        else if (edge_seen)
            dist_ff <= 11'h000;
        else if (tick && (dist_ff != 11'h7ff))
            dist_ff <= dist_ff + 11'h001;
    end
endmodule // rxcnc_edge_win

// ---- rxcnc_top.v ----
/*
 receiver digital control: programming frames on the open-drain data line,
 the two configuration registers, polling and bit check sequencing, data
 clock generation and noise suppression at the end of a stream.
 assumes demod_data, polling_sel, supply_dip and data_in are synchronous to
 mclk, and that the pad resolves data_oe high as the line pulled low.
*/
`timescale 1ns/100ps
`include "rxcnc_map.vh"
module rxcnc_top (
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // open-drain data line
    input wire data_in,
    output wire data_out,
    output wire data_oe,
    output wire data_clk,
    // host control pin, high allows polling
    input wire polling_sel,
    // front end
    input wire demod_data,
    input wire supply_dip,
    output wire modulation_select,
    output wire [1:0] baud_band_select,
    // status
    output wire ic_active,
    output wire reset_marker,
    output wire prog_ready
);
    localparam ST_SLEEP = 2'h0;
    localparam ST_START = 2'h1;
    localparam ST_CHECK = 2'h2;
    localparam ST_RECV = 2'h3;
    localparam integer DIV_LAST_I = `RXCNC_TCLK_CYC - 1;
    localparam integer DLY_LAST_I = `RXCNC_TDELAY2_CYC - 1;
    localparam [7:0] DIV_LAST = DIV_LAST_I[7:0];
    localparam [5:0] DLY_LAST = DLY_LAST_I[5:0];

    reg [7:0] div_ff;
    reg tick_ff;
    reg [11:0] op_ff;
    reg [11:0] win_ff;
    reg marker_ff;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [3:0] chk_ff;
    reg [3:0] nxt_chk;
    reg started_ff;
    reg nxt_started;
    reg supp_ff;
    reg nxt_supp;
    reg [17:0] sleep_ff;
    reg [17:0] nxt_sleep;
    reg [3:0] chk_need;
    reg demod_prev_ff;
    reg over_prev_ff;
    reg dpend_ff;
    reg dlvl_ff;
    reg dwait_ff;
    reg [5:0] dly_ff;
    reg data_clk_ff;
    reg [5:0] eos_ff;
    reg data_oe_ff;
    reg host_low_prev_ff;
    reg [3:0] low_ff;
    reg [6:0] gap_ff;
    reg [3:0] bits_ff;
    reg [14:0] frame_ff;
    reg fr_valid_ff;

    wire in_t;
    wire in_2t;
    wire over;
    wire buf_valid;
    wire [14:0] buf_data;
    wire [1:0] scale_log2 = ~op_ff[`RXCNC_OP_BAND]; // [R16]
    wire [4:0] sleep_cnt = op_ff[`RXCNC_OP_SLEEP];
    wire dem_edge = demod_data ^ demod_prev_ff;
    wire over_rise = over && !over_prev_ff;
    wire in_recv = (state_ff == ST_RECV);
    wire end_ev = in_recv && started_ff && over_rise;
    wire host_low = !data_in && !data_oe_ff;
    // commits wait while a data clock is in flight so limits stay put
    wire buf_ready = !dpend_ff && !dwait_ff;
    wire fr_take = buf_valid && buf_ready;
    wire cmd_off = fr_take && buf_data[`RXCNC_FR_OFF]; // [R11]
    wire cmd_wr = fr_take && !buf_data[`RXCNC_FR_OFF] && !buf_data[`RXCNC_FR_STOP]; // [R13]
    wire wr_op = cmd_wr && buf_data[`RXCNC_FR_SEL]; // [R12]
    wire wr_win = cmd_wr && !buf_data[`RXCNC_FR_SEL]; // [R12]
    wire clk_edge = in_recv && dem_edge && !marker_ff && !end_ev && (started_ff ? (in_t || in_2t) : in_2t);
    // sleep time in timing ticks: count x scale x 1024
    wire [17:0] sleep_load = op_ff[`RXCNC_OP_XSLEEP] ? {sleep_cnt, 13'h0000} : {3'h0, sleep_cnt, 10'h000}; // [R18]
    wire [5:0] eos_load = `RXCNC_EOS_PULSE_TICKS << scale_log2; // [R3]

    assign data_out = 1'b0; // open drain: only ever pulls low
    assign data_oe = data_oe_ff;
    assign data_clk = data_clk_ff;
    assign modulation_select = op_ff[`RXCNC_OP_MOD]; // [R14]
    assign baud_band_select = op_ff[`RXCNC_OP_BAND]; // [R14]
    assign ic_active = (state_ff != ST_SLEEP);
    assign reset_marker = marker_ff;

    // frame holding buffer between line decoder and register commit
    rxcnc_buf2 u_buf (
        .mclk(mclk),
        .reset_n(reset_n),
        .in_valid(fr_valid_ff),
        .in_ready(prog_ready),
        .in_data(frame_ff),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );

    // edge distance classification against the programmed window
    rxcnc_edge_win u_win (
        .mclk(mclk),
        .reset_n(reset_n),
        .tick(tick_ff),
        .edge_seen(dem_edge),
        .lim_min(win_ff[`RXCNC_WIN_MIN]), // [R15]
        .lim_max(win_ff[`RXCNC_WIN_MAX]), // [R15]
        .scale_log2(scale_log2),
        .in_t(in_t),
        .in_2t(in_2t),
        .over(over)
    );

    // internal timing clock as a one-cycle enable
    always @(posedge mclk) begin
        if (!reset_n) begin
            div_ff <= 8'h00;
            tick_ff <= 1'b0;
        end else if (div_ff == DIV_LAST) begin
            div_ff <= 8'h00;
            tick_ff <= 1'b1;
        end else begin
            div_ff <= div_ff + 8'h01;
            tick_ff <= 1'b0;
        end
    end

    // configuration registers; a dip outranks a write in the same cycle
    always @(posedge mclk) begin
        if (!reset_n) begin
            op_ff <= `RXCNC_OP_RESET; // [R10]
            win_ff <= `RXCNC_WIN_RESET; // [R10]
            marker_ff <= 1'b0;
        end else if (supply_dip) begin
            op_ff <= `RXCNC_OP_RESET; // [R20]
            win_ff <= `RXCNC_WIN_RESET; // [R20]
            marker_ff <= 1'b1; // [R9]
        end else begin
            if (wr_op)
                op_ff <= buf_data[`RXCNC_FR_PAY]; // [R8] [R14]
            if (wr_win)
                win_ff <= buf_data[`RXCNC_FR_PAY]; // [R8] [R15]
            if (wr_op || wr_win)
                marker_ff <= 1'b0; // [R20]
        end
    end

    // number of bits the check must see
    always @* begin
        case (op_ff[`RXCNC_OP_CHK])
            2'h0: chk_need = `RXCNC_CHK_N0; // [R17]
            2'h1: chk_need = `RXCNC_CHK_N1; // [R17]
            2'h2: chk_need = `RXCNC_CHK_N2; // [R17]
            default: chk_need = `RXCNC_CHK_N3; // [R17]
        endcase
    end

    // mode sequencing: sleep, start-up, bit check, receiving
    always @* begin
        nxt_state = state_ff;
        nxt_chk = chk_ff;
        nxt_started = started_ff;
        nxt_supp = supp_ff;
        nxt_sleep = sleep_ff;
        case (state_ff)
            ST_SLEEP: begin
                if (!polling_sel) begin
                    nxt_state = ST_RECV; // [R5]
                    nxt_started = 1'b0;
                    nxt_supp = 1'b0;
                end else if (sleep_cnt == `RXCNC_SLEEP_PERM) begin
                    nxt_state = ST_SLEEP; // [R18]
                end else if (sleep_ff == 18'h00000) begin
                    nxt_state = ST_CHECK; // [R18]
                    nxt_chk = 4'h0;
                end else if (tick_ff) begin
                    nxt_sleep = sleep_ff - 18'h00001;
                end
            end
            ST_START: begin
                nxt_chk = 4'h0;
                nxt_sleep = sleep_load; // [R18]
                // a low polling pin skips sleep but still checks
                nxt_state = polling_sel ? ST_SLEEP : ST_CHECK; // [R6] [R7]
            end
            ST_CHECK: begin
                if (chk_need == `RXCNC_CHK_N0) begin
                    nxt_state = ST_RECV;
                    nxt_started = 1'b0;
                    nxt_supp = 1'b0;
                end else if (dem_edge && in_t) begin
                    if (chk_ff + 4'h1 == chk_need) begin
                        nxt_state = ST_RECV; // [R2] [R6]
                        nxt_started = 1'b0;
                        nxt_supp = 1'b0;
                    end else begin
                        nxt_chk = chk_ff + 4'h1;
                    end
                end else if (dem_edge || over_rise) begin
                    nxt_chk = 4'h0;
                    // after a stream or under host control keep checking
                    if (polling_sel && !supp_ff)
                        nxt_state = ST_START;
                end
            end
            default: begin
                if (end_ev) begin
                    nxt_started = 1'b0;
                    if (op_ff[`RXCNC_OP_NOISE]) begin
                        nxt_state = ST_CHECK; // [R2]
                        nxt_supp = 1'b1;
                        nxt_chk = 4'h0;
                    end
                    // with suppression off noise keeps flowing [R4]
                end else if (dem_edge && !started_ff && in_2t) begin
                    nxt_started = 1'b1;
                end else if (dem_edge && !in_t && !in_2t) begin
                    nxt_started = 1'b0; // code violation stops the clock
                end
            end
        endcase
        if (cmd_off) begin
            nxt_state = ST_START; // [R6] [R11]
            nxt_started = 1'b0;
            nxt_supp = 1'b0;
        end
    end

    // state registers
    always @(posedge mclk) begin
        if (!reset_n) begin
            state_ff <= ST_START;
            chk_ff <= 4'h0;
            started_ff <= 1'b0;
            supp_ff <= 1'b0;
            sleep_ff <= 18'h00000;
            demod_prev_ff <= 1'b1;
            over_prev_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            chk_ff <= nxt_chk;
            started_ff <= nxt_started;
            supp_ff <= nxt_supp;
            sleep_ff <= nxt_sleep;
            demod_prev_ff <= demod_data;
            over_prev_ff <= over;
        end
    end

    // data clock waits for the line to reach the driven level, then delays
    always @(posedge mclk) begin
        if (!reset_n) begin
            dpend_ff <= 1'b0;
            dlvl_ff <= 1'b1;
            dwait_ff <= 1'b0;
            dly_ff <= 6'h00;
            data_clk_ff <= 1'b0;
        end else begin
            data_clk_ff <= 1'b0;
            // a marker cancels a clock already in flight
            if (!in_recv || !nxt_started || marker_ff) begin // [R20]
                dpend_ff <= 1'b0;
                dwait_ff <= 1'b0;
            end else if (clk_edge) begin
                dpend_ff <= 1'b1;
                dlvl_ff <= demod_data;
                dwait_ff <= 1'b0;
            end else if (dpend_ff && (data_in == dlvl_ff) && (data_oe_ff == !dlvl_ff)) begin
                dpend_ff <= 1'b0; // [R1]
                dwait_ff <= 1'b1;
                dly_ff <= 6'h00;
            end else if (dwait_ff) begin
                if (dly_ff == DLY_LAST) begin
                    dwait_ff <= 1'b0;
                    data_clk_ff <= 1'b1; // [R1]
                end else begin
                    dly_ff <= dly_ff + 6'h01;
                end
            end
        end
    end

    // line drive: stream in receiving, marker low, end-of-stream pulse
    always @(posedge mclk) begin
        if (!reset_n) begin
            eos_ff <= 6'h00;
            data_oe_ff <= 1'b0;
        end else begin
            if (end_ev && op_ff[`RXCNC_OP_NOISE] && !demod_data)
                eos_ff <= eos_load; // [R3]
            else if (tick_ff && (eos_ff != 6'h00))
                eos_ff <= eos_ff - 6'h01;
            if (eos_ff != 6'h00)
                data_oe_ff <= 1'b1; // [R3]
            else if (nxt_state == ST_RECV)
                data_oe_ff <= marker_ff || !demod_data; // [R4] [R9]
            else
                data_oe_ff <= 1'b0; // [R2]
        end
    end

    // programming frames: short host low pulse is 0, long is 1
    always @(posedge mclk) begin
        if (!reset_n) begin
            host_low_prev_ff <= 1'b0;
            low_ff <= 4'h0;
            gap_ff <= 7'h00;
            bits_ff <= 4'h0;
            frame_ff <= 15'h0000;
            fr_valid_ff <= 1'b0;
        end else begin
            host_low_prev_ff <= host_low;
            fr_valid_ff <= 1'b0;
            if (host_low) begin
                gap_ff <= 7'h00;
                if (tick_ff && (low_ff != 4'hf))
                    low_ff <= low_ff + 4'h1;
            end else if (host_low_prev_ff) begin
                low_ff <= 4'h0;
                // pulses shorter than one tick are glitches
                if (low_ff != 4'h0) begin
                    frame_ff <= {frame_ff[13:0], (low_ff >= `RXCNC_PROG_ONE_TICKS)}; // [R19]
                    if (bits_ff == `RXCNC_FR_LAST) begin
                        bits_ff <= 4'h0;
                        fr_valid_ff <= 1'b1; // [R19]
                    end else begin
                        bits_ff <= bits_ff + 4'h1;
                    end
                end
            end else if (tick_ff) begin
                if (gap_ff == `RXCNC_PROG_GAP_TICKS)
                    bits_ff <= 4'h0;
                else
                    gap_ff <= gap_ff + 7'h01;
            end
        end
    end
endmodule // rxcnc_top

// ---- rxcnc_chk_sva.sv ----
/*
 checker for the receiver control top: reset values, supply dip marker and
 the data clock pulse.
 assumes it is bound onto rxcnc_top, one clock, synchronous active-low reset.
*/
`timescale 1ns/100ps
module rxcnc_chk (
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // open-drain line and data clock
    input wire data_in,
    input wire data_out,
    input wire data_oe,
    input wire data_clk,
    // front end and status
    input wire supply_dip,
    input wire modulation_select,
    input wire [1:0] baud_band_select,
    input wire ic_active,
    input wire reset_marker
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    // band and modulation outputs of the operation register back at their reset values
    sequence s_defaults;
        baud_band_select == 2'b00 && !modulation_select;
    endsequence
    // defaults reloaded and the marker shown
    sequence s_reload;
        s_defaults ##0 reset_marker;
    endsequence
    // one-cycle clock pulse
    sequence s_pulse;
        data_clk ##1 !data_clk;
    endsequence

    AST_OUT_LOW: assert property (data_out == 1'b0)
        else $error("data line value not zero");
    AST_RESET_DEFAULTS: assert property ($rose(reset_n) |-> s_defaults ##0 (!reset_marker && ic_active))
        else $error("reset values wrong");
    AST_RESET_QUIET: assert property ($rose(reset_n) |-> !data_oe && !data_clk)
        else $error("line driven at reset");
    AST_DIP_RELOAD: assert property (supply_dip |=> s_reload)
        else $error("dip did not reload defaults");
    AST_MARKER_CAUSE: assert property ($rose(reset_marker) |-> $past(supply_dip))
        else $error("marker rose without a dip");
    AST_MARKER_HOLDS: assert property ($rose(reset_marker) |=> reset_marker [*8])
        else $error("marker dropped too soon");
    AST_CLK_PULSE: assert property (data_clk |-> s_pulse)
        else $error("data clock wider than one cycle");
    AST_CLK_MATCH: assert property (data_clk |-> $past(data_in, 40) != $past(data_oe, 40) &&
            $past(data_in, 2) != $past(data_oe, 2))
        else $error("data clock before line settled");
    AST_CLK_NO_MARKER: assert property (reset_marker && $past(reset_marker) |-> !data_clk)
        else $error("data clock while marker shown");
endmodule // rxcnc_chk

bind rxcnc_top rxcnc_chk rxcnc_chk_i (
    .mclk(mclk),
    .reset_n(reset_n),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe(data_oe),
    .data_clk(data_clk),
    .supply_dip(supply_dip),
    .modulation_select(modulation_select),
    .baud_band_select(baud_band_select),
    .ic_active(ic_active),
    .reset_marker(reset_marker)
);

// ---- rxcnc_host.sv ----
/*
 host model: programming frames as low pulses on the open-drain line, and
 the polling pin.
 assumes the bench merges host_low and the device pull into one line level.
*/
`timescale 1ns/100ps
module rxcnc_host (
    // clock
    input wire mclk,
    // line
    input wire data_oe,
    output logic host_low,
    // control pin
    output logic polling_sel
);
    initial begin
        host_low = 1'b0;
        polling_sel = 1'b1;
    end

    // first bit first, long low for one, short low for zero
    // waits for the device to let go, since pulls under its own are invisible
    task automatic send_frame(input logic [14:0] fr);
        for (int i = 14; i >= 0; i--) begin
            while (data_oe !== 1'b0) @(posedge mclk);
            host_low <= 1'b1;
            repeat (fr[i] ? 810 : 210) @(posedge mclk);
            host_low <= 1'b0;
            repeat (20) @(posedge mclk); // a short gap keeps each frame brief
        end
    endtask

    // low keeps receiving for manual suppression, high resumes polling
    task automatic set_polling(input logic lvl);
        polling_sel <= lvl;
        @(posedge mclk);
    endtask
endmodule // rxcnc_host

// ---- tb_top.sv ----
/*
 self-checking bench for the receiver control top: register writes, a
 discarded frame, supply dip marker, off command and a short coded stream.
 assumes the host model and the bound checker are compiled with it.
*/
`timescale 1ns/100ps
`include "rxcnc_map.vh"
`define CHK(what, e, g) \
    begin \
        n_checks++; \
        if ((g) !== (e)) begin \
            n_mismatch++; \
            $display("ERROR %s expected %h seen %h", what, e, g); \
        end \
    end
module tb_top;
    localparam logic [11:0] OP_DEF = `RXCNC_OP_RESET;
    logic mclk, reset_n, supply_dip, demod_data, obs_req, act_clr, act_seen;
    wire data_in, data_out, data_oe, data_clk, polling_sel, host_low;
    wire modulation_select, ic_active, reset_marker, prog_ready;
    wire [1:0] baud_band_select;
    logic [4:0] exp_q[$];
    logic [4:0] exp_now;
    logic [3:0] exp_clk_q[$];
    logic [3:0] exp_clk, exp_clk_now, clk_cnt;
    int n_mismatch, n_checks;

    // open-drain line with pull-up
    assign data_in = !(host_low || data_oe);

    rxcnc_top rxcnc_top_i (
        .mclk(mclk),
        .reset_n(reset_n),
        .data_in(data_in),
        .data_out(data_out),
        .data_oe(data_oe),
        .data_clk(data_clk),
        .polling_sel(polling_sel),
        .demod_data(demod_data),
        .supply_dip(supply_dip),
        .modulation_select(modulation_select),
        .baud_band_select(baud_band_select),
        .ic_active(ic_active),
        .reset_marker(reset_marker),
        .prog_ready(prog_ready)
    );
    rxcnc_host rxcnc_host_i (
        .mclk(mclk),
        .data_oe(data_oe),
        .host_low(host_low),
        .polling_sel(polling_sel)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // sticky wake flag, so a one-cycle pass through start-up is not missed, and a data clock count
    always @(posedge mclk) begin
        if (act_clr) act_seen <= 1'b0;
        else if (ic_active === 1'b1) act_seen <= 1'b1;
        if (act_clr) clk_cnt <= 4'h0;
        else if (data_clk === 1'b1) clk_cnt <= clk_cnt + 4'h1;
    end

    // compares the oldest note with the outputs when a result is due
    always @(posedge mclk) begin
        if (obs_req === 1'b1) begin
            exp_now = exp_q.pop_front();
            `CHK("config", exp_now, {baud_band_select, modulation_select, reset_marker, act_seen})
            exp_clk_now = exp_clk_q.pop_front();
            `CHK("data clocks", exp_clk_now, clk_cnt)
        end
    end

    task automatic clr_act();
        act_clr <= 1'b1;
        @(posedge mclk);
        act_clr <= 1'b0;
    endtask

    // commit lands a few cycles after the last bit, so allow ten
    task automatic note(input logic [4:0] e);
        repeat (10) @(posedge mclk);
        exp_q.push_back(e);
        exp_clk_q.push_back(exp_clk);
        obs_req <= 1'b1;
        @(posedge mclk);
        obs_req <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic frame(input logic [14:0] fr);
        clr_act();
        rxcnc_host_i.send_frame(fr);
    endtask

    // operation frame: band, check count, modulation, sleep 31, scale 1
    function automatic logic [14:0] op_fr(input logic [1:0] b, input logic [1:0] c, input logic m,
                                          input logic stop);
        return {2'b01, b, c, m, 5'h1f, 1'b0, c[0], stop};
    endfunction

    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // seven frames and a short stream take about 80000 cycles
    initial begin
        repeat (100000) @(posedge mclk);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        logic [1:0] chk;
        logic m;
        reset_n = 1'b0;
        supply_dip = 1'b0;
        demod_data = 1'b1;
        obs_req = 1'b0;
        act_clr = 1'b0;
        exp_clk = 4'h0;
        n_mismatch = 0;
        n_checks = 0;
        void'($urandom(32'hdef13022));
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        // defaults hold without programming, device asleep with polling high
        clr_act();
        note({OP_DEF[11:10], OP_DEF[7], 2'b00});
        // first three band codes, random check count and modulation
        for (int b = 0; b < 3; b++) begin
            chk = 2'($urandom);
            m = 1'($urandom);
            frame(op_fr(2'(b), chk, m, 1'b0));
            note({2'(b), m, 2'b00});
        end
        // a dip throws away band 2 and shows the marker
        supply_dip <= 1'b1;
        @(posedge mclk);
        supply_dip <= 1'b0;
        repeat (3) @(posedge mclk);
        clr_act();
        note({OP_DEF[11:10], OP_DEF[7], 2'b10});
        // host reprograms the window: limits 10 and 14, marker clears
        frame({2'b00, 6'd10, 6'd14, 1'b0});
        note({OP_DEF[11:10], OP_DEF[7], 2'b00});
        m = 1'($urandom);
        frame(op_fr(2'b11, chk, m, 1'b0));
        note({2'b11, m, 2'b00});
        // stop bit one must leave the register alone
        frame(op_fr(2'b00, chk, !m, 1'b1));
        note({2'b11, m, 2'b00});
        // off command wakes through start-up, rest of frame ignored
        frame({1'b1, 14'($urandom)});
        note({2'b11, m, 2'b01});
        // polling low: start bit of 2T then plain T edges at scale 1
        clr_act();
        rxcnc_host_i.set_polling(1'b0);
        demod_data <= 1'b0;
        repeat (2400) @(posedge mclk);
        demod_data <= 1'b1;
        repeat (4800) @(posedge mclk);
        for (int k = 0; k < 5; k++) begin
            demod_data <= ~demod_data;
            repeat (2400) @(posedge mclk);
        end
        // the start bit and four plain edges each give one data clock
        exp_clk = 4'h5;
        note({2'b11, m, 2'b01});
        rxcnc_host_i.set_polling(1'b1);
        tally_and_finish();
    end
endmodule // tb_top
